//--- verilog/slc_pkg.sv
// Package with register map, field layout, levels and timing for the segment display controller.
package slc_pkg;
  localparam int NUM_SEG      = 25;
  localparam int NUM_COM      = 4;
  localparam int REGS_PER_COM = 5;
  localparam int NUM_DATA     = NUM_COM * REGS_PER_COM;
  localparam int ADDR_W       = 12;

  localparam logic [11:0] ADDR_CTRL_A   = 12'h000;
  localparam logic [11:0] ADDR_CTRL_B   = 12'h004;
  localparam logic [11:0] ADDR_FRAME    = 12'h008;
  localparam logic [11:0] ADDR_CONTRAST = 12'h00C;
  localparam logic [11:0] ADDR_STATUS   = 12'h010;
  localparam logic [11:0] ADDR_DATA     = 12'h040;

  // Control A bits.
  localparam int CA_EN    = 0;
  localparam int CA_LPW   = 1;
  localparam int CA_BLANK = 2;
  localparam int CA_IE    = 3;
  localparam int CA_FLAG  = 4;
  // Control B fields.
  localparam int CB_SEL   = 0;
  localparam int CB_DUTY  = 1;
  localparam int CB_BIAS  = 3;
  localparam int CB_SEGN  = 5;
  // Frame rate fields.
  localparam int FR_PS    = 0;
  localparam int FR_CD    = 4;
  // Contrast fields.
  localparam int CC_LEVEL = 0;
  localparam int CC_DRV   = 4;

  localparam logic [4:0] SEGN_RESET = 5'h19;

  // Prescaler: code 0 divides by 2^4, code k>0 by 2^(k+5).
  localparam int PS_BITS      = 12;
  localparam int PS_SHIFT_MIN = 4;
  localparam int PS_SHIFT_OFS = 5;

  // Buffer drive time step; drive time is (field+1) steps.
  localparam int CLK_PERIOD_NS = 10;
  localparam int DRV_STEP_NS   = 100;
  localparam int DRV_STEP_CYC  = (DRV_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Pin levels in fractions of the panel drive voltage.
  localparam logic [1:0] LV_GND = 2'h0;
  localparam logic [1:0] LV_LO  = 2'h1;
  localparam logic [1:0] LV_HI  = 2'h2;
  localparam logic [1:0] LV_TOP = 2'h3;

  localparam logic [1:0] BIAS_STATIC = 2'h0;
  localparam logic [1:0] BIAS_HALF   = 2'h1;
  localparam logic [1:0] BIAS_THIRD  = 2'h2;
  localparam logic [1:0] DUTY_STATIC = 2'h0;

  typedef struct packed {
    logic       clk_sel;
    logic [1:0] duty;
    logic [1:0] bias;
    logic [4:0] seg_cnt;
    logic [2:0] ps;
    logic [2:0] cd;
    logic [2:0] drv;
    logic [3:0] contrast;
  } slc_cfg_s;

  typedef struct packed {
    logic       blank;
    logic       lpw;
    logic [3:0] contrast;
  } slc_frame_s;
endpackage

//--- verilog/slc_segment_lcd_controller.sv
// Segment display controller: APB registers, clock prescaler, common scan and pin level drive.
`timescale 1ns/1ps
module slc_segment_lcd_controller #(
  parameter int NSEG = slc_pkg::NUM_SEG,
  parameter int NCOM = slc_pkg::NUM_COM
) (
  input  wire logic                  clk_sys,               // System clock, 100 MHz.
  input  wire logic                  rst_n,                 // Synchronous reset, active low.
  input  wire logic [slc_pkg::ADDR_W-1:0] paddr,            // APB byte address.
  input  wire logic                  psel,                  // APB select.
  input  wire logic                  penable,               // APB access phase.
  input  wire logic                  pwrite,                // APB write.
  input  wire logic [31:0]           pwdata,                // APB write data.
  output logic      [31:0]           prdata,                // APB read data.
  output logic                       pready,                // APB ready.
  output logic                       pslverr,               // APB error on unmapped address.
  input  wire logic                  timer_osc_input_pin,   // Asynchronous oscillator pin.
  input  wire logic                  vlcd_ready_pin,        // Drive voltage at target.
  input  wire logic                  display_power_off_bit, // Module held off while high.
  output logic      [2*NSEG-1:0]     seg_level,             // Level code per segment pin.
  output logic      [2*NCOM-1:0]     com_level,             // Level code per common pin.
  output logic      [NSEG-1:0]       seg_oe,                // Segment pin driven.
  output logic      [NCOM-1:0]       com_oe,                // Common pin driven.
  output logic      [NSEG-1:0]       seg_own,               // Segment pin owned by display.
  output logic      [NCOM-1:0]       com_own,               // Common pin owned by display.
  output logic      [3:0]            contrast_out,          // Drive voltage target code.
  output logic                       irq                    // Frame interrupt request.
);
  import slc_pkg::*;

  localparam int NDATA = NCOM * REGS_PER_COM;

  logic [7:0]  mem [NDATA];
  logic [7:0]  lat [NDATA];
  slc_cfg_s    cfg;
  slc_frame_s  frm;
  logic        en, lpw, blank, ie, flag;
  logic        osc_s1, osc_s2, osc_s3, rdy_s1, rdy_s2;
  logic [PS_BITS-1:0] ps_cnt;
  logic [2:0]  div_cnt;
  logic [1:0]  com_idx;
  logic        phase, fpar, act_q;
  logic [7:0]  dcnt;

  function automatic logic [PS_BITS-1:0] ps_mask(input logic [2:0] code);
    int sh;
    sh = (code == 3'h0) ? PS_SHIFT_MIN : int'(code) + PS_SHIFT_OFS;
    return PS_BITS'((1 << sh) - 1);
  endfunction

  function automatic logic [1:0] com_lv(input logic sel, input logic pol, input logic [1:0] b);
    if (sel || b == BIAS_STATIC)
      return pol ? LV_TOP : LV_GND;
    else if (b == BIAS_HALF)
      return LV_LO;
    else
      return pol ? LV_LO : LV_HI;
  endfunction

  function automatic logic [1:0] seg_lv(input logic on, input logic pol, input logic [1:0] b);
    if (on)
      return pol ? LV_GND : LV_TOP;
    else if (b == BIAS_THIRD)
      return pol ? LV_HI : LV_LO;
    else
      return pol ? LV_TOP : LV_GND;
  endfunction

  // APB decode. The slave answers in the second access cycle.
  wire         acc      = psel & penable;
  wire         done     = acc & pready;
  wire         wr       = done & pwrite;
  wire [11:0]  a12      = 12'(paddr);
  wire [11:0]  doff     = a12 - ADDR_DATA;
  wire [9:0]   didx     = doff[11:2];
  wire         is_data  = (a12 >= ADDR_DATA) && (didx < 10'(NDATA)) && (a12[1:0] == 2'h0);
  wire         is_ca    = a12 == ADDR_CTRL_A;
  wire         is_cb    = a12 == ADDR_CTRL_B;
  wire         is_fr    = a12 == ADDR_FRAME;
  wire         is_cc    = a12 == ADDR_CONTRAST;
  wire         is_st    = a12 == ADDR_STATUS;
  wire         mapped   = is_data | is_ca | is_cb | is_fr | is_cc | is_st;
  wire         lcd_on   = en & ~display_power_off_bit;
  wire         active   = lcd_on & rdy_s2;
  wire [31:0]  rd_ca    = 32'({flag, ie, blank, lpw, en});
  wire [31:0]  rd_cb    = 32'({cfg.seg_cnt, cfg.bias, cfg.duty, cfg.clk_sel});
  wire [31:0]  rd_fr    = 32'({cfg.cd, 1'b0, cfg.ps});
  wire [31:0]  rd_cc    = 32'({cfg.drv, cfg.contrast});
  wire [31:0]  rd_st    = 32'({rdy_s2, active, com_idx});
  wire [31:0]  rd_data  = is_data ? 32'(mem[didx[4:0]]) : 32'h0;
  wire [31:0]  rdata    = is_ca ? rd_ca : is_cb ? rd_cb : is_fr ? rd_fr :
                          is_cc ? rd_cc : is_st ? rd_st : rd_data;

  // Clock chain.
  wire         osc_edge = osc_s2 & ~osc_s3;
  wire         src_tick = cfg.clk_sel ? osc_edge : 1'b1;
  wire         ps_hit   = &(ps_cnt | ~ps_mask(cfg.ps));
  wire         ps_tick  = src_tick & ps_hit;
  wire         lcd_tick = ps_tick & (div_cnt == cfg.cd);

  // Scan sequencing.
  wire [1:0]   bias_eff = (cfg.duty == DUTY_STATIC) ? BIAS_STATIC : cfg.bias;
  wire         last_com = com_idx == cfg.duty;
  wire         slot_end = frm.lpw | phase;
  wire         frm_end  = lcd_tick & last_com & slot_end;
  wire         start    = active & (~act_q | frm_end);
  wire         do_latch = start & (~act_q | ~frm.lpw | fpar);
  wire         pol      = frm.lpw ? fpar : phase;
  wire         show     = active & ~frm.blank;
  wire [7:0]   drv_lim  = 8'((int'(cfg.drv) + 1) * DRV_STEP_CYC);
  wire         buf_on   = dcnt < drv_lim;

  logic [2*NSEG-1:0] next_seg_level;
  logic [2*NCOM-1:0] next_com_level;
  logic [NSEG-1:0]   next_seg_oe, next_seg_own;
  logic [NCOM-1:0]   next_com_oe, next_com_own;

  always_comb begin
    int r;
    r = 0;
    for (int c = 0; c < NCOM; c++) begin
      next_com_level[2*c+:2] = show ? com_lv(com_idx == 2'(c), pol, bias_eff) : LV_GND;
      next_com_own[c]        = lcd_on & (2'(c) <= cfg.duty);
      // Pins float until the drive voltage is ready, so no partial level reaches the panel.
      next_com_oe[c]         = next_com_own[c] & active &
                               (buf_on | next_com_level[2*c+:2] == LV_GND |
                                next_com_level[2*c+:2] == LV_TOP);
    end
    for (int s = 0; s < NSEG; s++) begin
      r = int'(com_idx) * REGS_PER_COM + s / 8;
      next_seg_level[2*s+:2] = show ? seg_lv(lat[r][s%8], pol, bias_eff) : LV_GND;
      next_seg_own[s]        = lcd_on & (5'(s) < cfg.seg_cnt);
      next_seg_oe[s]         = next_seg_own[s] & active &
                               (buf_on | next_seg_level[2*s+:2] == LV_GND |
                                next_seg_level[2*s+:2] == LV_TOP);
    end
  end

  // Pin synchronisers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
    end else begin
      osc_s1 <= timer_osc_input_pin;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      rdy_s1 <= vlcd_ready_pin;
      rdy_s2 <= rdy_s1;
    end
  end

  // APB slave and registers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
      {en, lpw, blank, ie, flag} <= 5'h0;
      cfg <= '{seg_cnt: SEGN_RESET, default: '0};
      for (int i = 0; i < NDATA; i++)
        mem[i] <= 8'h0;
    end else begin
      pready  <= acc & ~pready;
      prdata  <= (acc & ~pready & ~pwrite) ? rdata : 32'h0;
      pslverr <= acc & ~pready & ~mapped;
      // A frame latch in the same cycle as a clearing write keeps the flag set.
      flag    <= do_latch | (flag & ~(wr & is_ca & pwdata[CA_FLAG]));
      if (wr & is_ca) begin
        en    <= pwdata[CA_EN];
        lpw   <= pwdata[CA_LPW];
        blank <= pwdata[CA_BLANK];
        ie    <= pwdata[CA_IE];
      end
      if (wr & is_cb) begin
        cfg.clk_sel <= pwdata[CB_SEL];
        cfg.duty    <= pwdata[CB_DUTY+:2];
        cfg.bias    <= pwdata[CB_BIAS+:2];
        cfg.seg_cnt <= pwdata[CB_SEGN+:5];
      end
      if (wr & is_fr) begin
        cfg.ps <= pwdata[FR_PS+:3];
        cfg.cd <= pwdata[FR_CD+:3];
      end
      if (wr & is_cc) begin
        cfg.contrast <= pwdata[CC_LEVEL+:4];
        cfg.drv      <= pwdata[CC_DRV+:3];
      end
      if (wr & is_data)
        mem[didx[4:0]] <= pwdata[7:0];
    end
  end

  // Prescaler, divider and common scan.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !active) begin
      ps_cnt  <= '0;
      div_cnt <= 3'h0;
      com_idx <= 2'h0;
      phase   <= 1'b0;
      fpar    <= 1'b0;
      act_q   <= 1'b0;
      dcnt    <= 8'h0;
    end else begin
      act_q <= 1'b1;
      if (src_tick)
        ps_cnt <= ps_cnt + 1'b1;
      if (ps_tick)
        div_cnt <= lcd_tick ? 3'h0 : div_cnt + 3'h1;
      if (lcd_tick | start)
        dcnt <= 8'h0;
      else if (dcnt != 8'hFF)
        dcnt <= dcnt + 8'h1;
      if (start)
        fpar <= act_q ? ~fpar : 1'b0;
      if (frm_end) begin
        com_idx <= 2'h0;
        phase   <= 1'b0;
      end else if (lcd_tick) begin
        phase <= ~slot_end;
        if (slot_end)
          com_idx <= com_idx + 2'h1;
      end
    end
  end

  // Frame latch of data and settings.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frm <= '0;
      for (int i = 0; i < NDATA; i++)
        lat[i] <= 8'h0;
    end else if (do_latch) begin
      frm <= '{blank: blank, lpw: lpw, contrast: cfg.contrast};
      lat <= mem;
    end
  end

  // Registered outputs.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      seg_level    <= '0;
      com_level    <= '0;
      seg_oe       <= '0;
      com_oe       <= '0;
      seg_own      <= '0;
      com_own      <= '0;
      contrast_out <= 4'h0;
      irq          <= 1'b0;
    end else begin
      seg_level    <= next_seg_level;
      com_level    <= next_com_level;
      seg_oe       <= next_seg_oe;
      com_oe       <= next_com_oe;
      seg_own      <= next_seg_own;
      com_own      <= next_com_own;
      contrast_out <= frm.contrast;
      irq          <= flag & ie;
    end
  end

  property p_src_sys;
    @(posedge clk_sys) disable iff (!rst_n)
      active && !cfg.clk_sel |=> ps_cnt == $past(ps_cnt) + 1'b1;
  endproperty
  a_src_sys: assert property (p_src_sys) else $error("prescaler stalled on system clock");

  property p_div;
    @(posedge clk_sys) disable iff (!rst_n) lcd_tick |=> div_cnt == 3'h0;
  endproperty
  a_div: assert property (p_div) else $error("divider not restarted after tick");

  property p_flag;
    @(posedge clk_sys) disable iff (!rst_n) do_latch |=> flag;
  endproperty
  a_flag: assert property (p_flag) else $error("frame flag not set on latch");

  property p_first_com;
    @(posedge clk_sys) disable iff (!rst_n) active && !act_q |=> com_idx == 2'h0 && act_q;
  endproperty
  a_first_com: assert property (p_first_com) else $error("first frame not at common zero");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !rdy_s2 |=> seg_level == '0 && com_level == '0 && seg_oe == '0 && com_oe == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("output before drive voltage ready");

  property p_latch_stable;
    @(posedge clk_sys) disable iff (!rst_n) !do_latch |=> $stable(frm);
  endproperty
  a_latch_stable: assert property (p_latch_stable) else $error("frame settings changed mid-frame");

  property p_off;
    @(posedge clk_sys) disable iff (!rst_n) !en |=> seg_own == '0 && com_own == '0;
  endproperty
  a_off: assert property (p_off) else $error("pins not released after disable");

  property p_blank;
    @(posedge clk_sys) disable iff (!rst_n) frm.blank |=> seg_level == '0 && com_level == '0;
  endproperty
  a_blank: assert property (p_blank) else $error("blanked frame drives a level");

  property p_scan;
    @(posedge clk_sys) disable iff (!rst_n) active |-> com_idx <= cfg.duty;
  endproperty
  a_scan: assert property (p_scan) else $error("common index beyond duty");

  property p_phase;
    @(posedge clk_sys) disable iff (!rst_n)
      active && !frm.lpw && lcd_tick && !phase && !frm_end |=> phase;
  endproperty
  a_phase: assert property (p_phase) else $error("slot polarity did not alternate");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n) flag && ie |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  c_latch: cover property (@(posedge clk_sys) disable iff (!rst_n) do_latch && act_q);
  c_blank: cover property (@(posedge clk_sys) disable iff (!rst_n) frm.blank && active);
  c_lpw:   cover property (@(posedge clk_sys) disable iff (!rst_n) frm.lpw && frm_end && !fpar);
endmodule

//--- dv/slc_panel_model.sv
// Panel side model: reservoir charge delay for the drive voltage and a DC monitor.
`timescale 1ns/1ps
module slc_panel_model #(
  parameter int CHARGE_CYC = 40
) (
  input  wire logic       clk_sys,        // System clock.
  input  wire logic       charge_en,      // Supply is charging the reservoir.
  input  wire logic       dc_clr,         // Restarts the DC sum.
  input  wire logic [1:0] seg0_level,     // Level code on segment zero.
  input  wire logic [1:0] common_line_zero_level,     // Level code on common zero.
  output logic            vlcd_ready_pin, // Drive voltage at target.
  output int              dc_sum          // Sum of segment minus common levels.
);
  int cnt;

  // A large reservoir charges slowly, so ready lags the supply by a fixed time.
  always_ff @(posedge clk_sys) begin
    cnt <= charge_en ? ((cnt < CHARGE_CYC) ? cnt + 1 : cnt) : 0;
    vlcd_ready_pin <= charge_en && (cnt >= CHARGE_CYC);
  end

  // A healthy drive averages to zero over whole frames.
  always_ff @(posedge clk_sys) begin
    if (dc_clr) begin
      dc_sum <= 0;
    end else begin
      dc_sum <= dc_sum + int'(seg0_level) - int'(common_line_zero_level);
    end
  end
endmodule

//--- dv/segment_lcd_controller_test.sv
// Self-checking bench for the segment display controller.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module segment_lcd_controller_test;
  import slc_pkg::*;
  logic        clk_sys, rst_n, psel, penable, pwrite, osc, pwr_off, charge, dc_clr, irq;
  logic        pready, pslverr, ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [49:0] seg_level;
  logic [7:0]  com_level;
  logic [24:0] seg_oe, seg_own;
  logic [3:0]  com_oe, com_own, contrast_out;
  int          err_total, compares, dc_sum;

  slc_segment_lcd_controller u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_osc_input_pin(osc), .vlcd_ready_pin(ready), .display_power_off_bit(pwr_off),
    .seg_level(seg_level), .com_level(com_level), .seg_oe(seg_oe), .com_oe(com_oe),
    .seg_own(seg_own), .com_own(com_own), .contrast_out(contrast_out), .irq(irq));

  slc_panel_model u_panel (
    .clk_sys(clk_sys), .charge_en(charge), .dc_clr(dc_clr), .seg0_level(seg_level[1:0]),
    .common_line_zero_level(com_level[1:0]), .vlcd_ready_pin(ready), .dc_sum(dc_sum));

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) err_total++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // Restarting through a disable keeps every configuration change frame aligned.
  task automatic cfg(input logic [1:0] du, input logic [1:0] bi, input logic [2:0] ps,
                     input logic [2:0] cd, input logic [2:0] dr, input logic sel);
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_CTRL_B, {22'h0, 5'h19, bi, du, sel});
    wr(ADDR_FRAME, {25'h0, cd, 1'b0, ps});
    wr(ADDR_CONTRAST, {25'h0, dr, 4'h9});
    wr(ADDR_CTRL_A, 32'h19);
  endtask

  task automatic edge_wait(output int n);
    logic [1:0] p;
    p = com_level[1:0];
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (com_level[1:0] === p && n < 3000);
  endtask

  task automatic wait_oe(input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (com_oe[1] !== v && n < 3000);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rd(ADDR_CTRL_B, q);
    `CHK("ctrl_b reset", 32'h320, q)
    wr(ADDR_DATA, 32'h1A5);
    rd(ADDR_DATA, q);
    `CHK("data width", 32'hA5, q)
    apb(1'b1, 12'h0FC, 32'h1, q, e);
    `CHK("unmapped err", 1'b1, e)
    apb(1'b0, ADDR_DATA + 12'h1, 32'h0, q, e);
    `CHK("misaligned err", 1'b1, e)
    `CHK("misaligned data", 32'h0, q)
  endtask

  task automatic t_hold;
    logic [31:0] q;
    cfg(2'h0, 2'h0, 3'h0, 3'h0, 3'h0, 1'b0);
    repeat (50) @(posedge clk_sys);
    `CHK("no drive early", 29'h0, {seg_oe, com_oe})
    rd(ADDR_STATUS, q);
    `CHK("not ready", 1'b0, q[3])
    charge <= 1'b1;
    repeat (60) @(posedge clk_sys);
    rd(ADDR_STATUS, q);
    `CHK("active", 1'b1, q[2])
    pwr_off <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("power off", 29'h0, {seg_own, com_own})
    pwr_off <= 1'b0;
  endtask

  task automatic t_static;
    logic [31:0] q;
    wr(ADDR_DATA, 32'h01);
    cfg(2'h0, 2'h0, 3'h0, 3'h0, 3'h2, 1'b0);
    repeat (4) @(posedge clk_sys);
    rd(ADDR_STATUS, q);
    `CHK("first com", 2'h0, q[1:0])
    rd(ADDR_CTRL_A, q);
    `CHK("frame flag", 1'b1, q[CA_FLAG])
    `CHK("irq", 1'b1, irq)
    `CHK("contrast", 4'h9, contrast_out)
    repeat (20) @(posedge clk_sys);
    `CHK("seg on", ~com_level[1:0], seg_level[1:0])
    `CHK("seg off", com_level[1:0], seg_level[3:2])
    dc_clr <= 1'b1;
    @(posedge clk_sys);
    dc_clr <= 1'b0;
    repeat (64) @(posedge clk_sys);
    #1;
    `CHK("dc sum", 0, dc_sum)
  endtask

  task automatic t_timing;
    int ps_t [4] = '{0, 1, 2, 0};
    int cd_t [4] = '{0, 2, 0, 7};
    int ex_t [4] = '{16, 192, 128, 128};
    int n;
    for (int i = 0; i < 4; i++) begin
      cfg(2'h0, 2'h0, 3'(ps_t[i]), 3'(cd_t[i]), 3'h0, 1'b0);
      edge_wait(n);
      edge_wait(n);
      `CHK("tick period", ex_t[i], n)
    end
    cfg(2'h0, 2'h0, 3'h0, 3'h0, 3'h0, 1'b1);
    edge_wait(n);
    edge_wait(n);
    `CHK("osc tick", 1'b1, n >= 63 && n <= 65)
  endtask

  task automatic t_scan;
    logic [31:0] q;
    logic [1:0]  b;
    logic [3:0]  seen;
    logic [1:0]  sq [$];
    for (int d = 0; d < 4; d++) begin
      b = (d == 0) ? 2'h0 : (d == 1) ? 2'h1 : 2'h2;
      cfg(2'(d), b, 3'h0, 3'h0, 3'h7, 1'b0);
      seen = 4'h0;
      sq.delete();
      for (int k = 0; k < 60; k++) begin
        rd(ADDR_STATUS, q);
        seen = seen | (4'h1 << com_level[1:0]);
        if (sq.size() == 0 || sq[$] !== q[1:0]) sq.push_back(q[1:0]);
      end
      `CHK("scan length", 1'b1, sq.size() >= ((d == 0) ? 1 : d + 2))
      foreach (sq[i]) `CHK("com order", 2'(i % (d + 1)), sq[i])
      `CHK("com owned", 4'((1 << (d + 1)) - 1), com_own)
      `CHK("levels used", (d == 0) ? 4'h9 : (d == 1) ? 4'hB : 4'hF, seen)
    end
  endtask

  // A rise into a full swing level runs long, so one into the mid level LV_LO is taken.
  task automatic t_drive;
    int dr_t [3] = '{0, 3, 7};
    int n;
    for (int i = 0; i < 3; i++) begin
      cfg(2'h1, 2'h1, 3'h0, 3'h7, 3'(dr_t[i]), 1'b0);
      wait_oe(1'b0, n);
      wait_oe(1'b1, n);
      if (com_level[3:2] !== 2'h1) begin
        wait_oe(1'b0, n);
        wait_oe(1'b1, n);
      end
      wait_oe(1'b0, n);
      `CHK("drive time", 1'b1, n >= 10 * dr_t[i] + 9 && n <= 10 * dr_t[i] + 11)
    end
  endtask

  // Low power wave at half duty, third bias: com zero goes straight to its unselected level,
  // and the level codes are linear here, so the sum over two frames must come to zero.
  task automatic t_lpw;
    int n;
    cfg(2'h1, 2'h2, 3'h0, 3'h0, 3'h0, 1'b0);
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_CTRL_A, 32'h1B);
    edge_wait(n);
    `CHK("lpw second level", LV_HI, com_level[1:0])
    dc_clr <= 1'b1;
    @(posedge clk_sys);
    dc_clr <= 1'b0;
    repeat (128) @(posedge clk_sys);
    #1;
    `CHK("lpw dc sum", 0, dc_sum)
  endtask

  task automatic t_off;
    logic [31:0] q;
    wr(ADDR_DATA, 32'h01);
    cfg(2'h0, 2'h0, 3'h0, 3'h0, 3'h0, 1'b0);
    wr(ADDR_CTRL_B, {22'h0, 5'h0A, 5'h0});
    wr(ADDR_CTRL_A, 32'h5);
    repeat (100) @(posedge clk_sys);
    `CHK("seg mask", 25'h3FF, seg_own)
    `CHK("blank seg", 50'h0, seg_level)
    `CHK("blank com", 8'h0, com_level)
    rd(ADDR_DATA, q);
    `CHK("memory kept", 32'h1, q)
    wr(ADDR_CTRL_A, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("released", 29'h0, {seg_own, com_own})
  endtask

  task end_sim;
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // The oscillator pin toggles every second clock edge, so it rises every four cycles.
  initial begin
    osc = 1'b0;
    forever begin
      repeat (2) @(posedge clk_sys);
      osc <= ~osc;
    end
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pwr_off = 1'b0;
    charge = 1'b0;
    dc_clr = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs;
    t_hold;
    t_static;
    t_timing;
    t_scan;
    t_drive;
    t_lpw;
    t_off;
    end_sim;
  end

  initial begin
    #1_000_000;
    err_total++;
    end_sim;
  end
endmodule
